// *** adcsq_pkg.sv ***
/*
  adcsq_pkg: shared constants and types of the converter control sequencer.
  assumes: a single 100 MHz system clock; used only with explicit scoping.
*/
package adcsq_pkg;

  // ***********************************************************************
  // timing
  // ***********************************************************************
  localparam int CLK_PERIOD_NS = 10;       // system clock period
  localparam int CONV_TIME_NS  = 2000;     // one conversion, plain default
  // cycles per conversion, rounded down, never below one
  localparam int CONV_CYC      = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1
                                 : CONV_TIME_NS / CLK_PERIOD_NS;

  // ***********************************************************************
  // widths and field layout
  // ***********************************************************************
  localparam int CH_W       = 5;           // analog input number width
  localparam int SAMPLE_W   = 10;          // converted sample width
  localparam int HIGH_W     = 8;           // high byte view of the result
  localparam int SLOT_W     = 2;           // scan slot index width
  localparam int CNT_W      = 12;          // conversion timer width
  localparam int SCAN_SLOTS = 4;           // channels per scan pass

  // ***********************************************************************
  // reset values
  // ***********************************************************************
  localparam logic [CH_W-1:0]     CH_RST     = 5'h00;
  localparam logic [SLOT_W-1:0]   SLOT_FIRST = 2'h0;
  localparam logic [SLOT_W-1:0]   SLOT_LAST  = 2'h3;
  localparam logic [SAMPLE_W-1:0] RES_RST    = 10'h000;
  localparam logic [CNT_W-1:0]    CNT_RST    = 12'h000;

  // ***********************************************************************
  // types
  // ***********************************************************************
  // operating mode, held stable by software outside the stop state
  typedef struct packed {
    logic wait_mode;                       // 1: trigger wait, 0: no-wait
    logic scan_mode;                       // 1: four-channel scan
    logic one_shot;                        // 1: one-shot, 0: sequential
  } adcsq_mode_t;

  // channel select register write
  typedef struct packed {
    logic            wr;                   // one-cycle write strobe
    logic [CH_W-1:0] ch;                   // input, or first scan channel
  } adcsq_chsel_t;

  // start bit write
  typedef struct packed {
    logic wr;                              // one-cycle write strobe
    logic val;                             // value written
  } adcsq_start_t;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_STOP  = 4'h1,                       // converter stopped
    ST_STBY  = 4'h2,                       // conversion standby
    ST_TRIG  = 4'h4,                       // hardware trigger standby
    ST_CONV  = 4'h8                        // converting
  } adcsq_state_t;

endpackage : adcsq_pkg

// *** adcsq_top.sv ***
/*
  adcsq_top: sequencer for an on-chip converter in hardware trigger modes.
  assumes: control bits, write strobes and the trigger come from logic on
  I_CLK; the analog core delivers I_SAMPLE valid at the end of each
  conversion window and restarts whenever O_SAMPLE_START pulses.
*/
// How it works
// RL1 - no-wait enable from stop enters standby
// RL2 - software waits stabilization before setting start
// RL3 - no-wait start only arms trigger standby
// RL4 - trigger with start set converts selected input
// RL5 - each conversion end stores result, raises irq
// RL6 - no-wait one-shot keeps start, back to trigger standby
// RL7 - scan converts slots zero to three in order
// RL8 - no-wait scan sequential repeats passes automatically
// RL9 - no-wait scan one-shot keeps start, awaits trigger
// RL10 - trigger mid-conversion aborts and restarts sequence
// RL11 - channel write mid-conversion restarts on new input
// RL12 - start rewrite mid-conversion restarts at first
// RL13 - no-wait start clear aborts, converter stays powered
// RL14 - enable clear in standby stops converter
// RL15 - no-wait triggers ignored while start is zero
// RL16 - start write ignored while enable is zero
// RL17 - wait-mode enable goes straight to trigger standby
// RL18 - wait-mode trigger converts and sets start
// RL19 - wait select sequential converts back to back
// RL20 - wait start clear aborts, converter powers down
// RL21 - wait-mode triggers ignored while enable is zero
// RL22 - trigger is one-cycle event, one restart
`timescale 1ns/1ps
module adcsq_top
#(
  parameter int CONV_CYCLES = adcsq_pkg::CONV_CYC   // cycles per conversion
)
(
  input  wire logic                           I_CLK,
  input  wire logic                           I_SRST,
  input  wire logic                           I_ENABLE,
  input  wire adcsq_pkg::adcsq_start_t        I_START,
  input  wire adcsq_pkg::adcsq_chsel_t        I_CHSEL,
  input  wire adcsq_pkg::adcsq_mode_t         I_MODE,
  input  wire logic                           I_HW_TRIG,
  input  wire logic [adcsq_pkg::SAMPLE_W-1:0] I_SAMPLE,
  output logic                                O_START_BIT,
  output logic [3:0]                          O_STATE,
  output logic                                O_CONV_POWER,
  output logic [adcsq_pkg::CH_W-1:0]          O_CONV_CH,
  output logic                                O_SAMPLE_START,
  output logic [adcsq_pkg::SAMPLE_W-1:0]      O_RESULT,
  output logic [adcsq_pkg::HIGH_W-1:0]        O_RESULT_HIGH,
  output logic                                O_EOC_IRQ
);

  // ***********************************************************************
  // helpers
  // ***********************************************************************
  // input number for a scan slot; scan covers four neighbouring inputs
  function automatic logic [adcsq_pkg::CH_W-1:0] slot_ch(
    input logic [adcsq_pkg::CH_W-1:0]   base,
    input logic [adcsq_pkg::SLOT_W-1:0] slot,
    input logic                         scan
  );
    logic [adcsq_pkg::CH_W-1:0] ofs;
    ofs = {{(adcsq_pkg::CH_W-adcsq_pkg::SLOT_W){1'b0}}, slot};
    slot_ch = scan ? base + ofs : base;
  endfunction : slot_ch

  localparam logic [adcsq_pkg::CNT_W-1:0] CNT_LAST =
    adcsq_pkg::CNT_W'(CONV_CYCLES - 1);

  // ***********************************************************************
  // state and storage
  // ***********************************************************************
  adcsq_pkg::adcsq_state_t               state_r, state_nxt;  // sequencer
  logic                                  start_r, start_nxt;  // start bit
  logic [adcsq_pkg::CH_W-1:0]            ch_r,    ch_nxt;     // channel sel
  logic [adcsq_pkg::SLOT_W-1:0]          slot_r,  slot_nxt;   // scan slot
  logic [adcsq_pkg::CNT_W-1:0]           cnt_r,   cnt_nxt;    // conv timer
  logic                                  trig_d_r;            // trigger last
  logic                                  go_r,    go_nxt;     // start pulse
  logic                                  eoc_r,   eoc_nxt;    // end pulse
  logic [adcsq_pkg::SAMPLE_W-1:0]        res_r,   res_nxt;    // result

  // ***********************************************************************
  // decoding
  // ***********************************************************************
  // RL22 one trigger event
  // a held trigger level counts once, on its rising edge
  wire trig_ev   = I_HW_TRIG & ~trig_d_r;
  wire wait_md   = I_MODE.wait_mode;
  wire scan_md   = I_MODE.scan_mode;
  wire one_shot  = I_MODE.one_shot;
  // RL16 start ignored when disabled
  wire st_wr     = I_START.wr & I_ENABLE;
  wire st_set    = st_wr &  I_START.val;
  wire st_clr    = st_wr & ~I_START.val;
  // RL15 gate trigger by start
  // RL21 gate trigger by enable
  wire trig_ok   = trig_ev & I_ENABLE & (wait_md | start_r);
  wire cnt_done  = (cnt_r == CNT_LAST);
  wire last_slot = ~scan_md | (slot_r == adcsq_pkg::SLOT_LAST);
  // any restart cause while converting
  wire restart   = trig_ok | st_set | I_CHSEL.wr;

  // ***********************************************************************
  // next-state logic
  // ***********************************************************************
  // one process keeps state, start bit, slot and timer in step
  always_comb
  begin
    state_nxt = state_r;
    start_nxt = start_r;
    ch_nxt    = I_CHSEL.wr ? I_CHSEL.ch : ch_r;
    slot_nxt  = slot_r;
    cnt_nxt   = cnt_r;
    go_nxt    = 1'b0;
    eoc_nxt   = 1'b0;
    res_nxt   = res_r;
    // start writes land in the bit unless overruled below
    if (st_wr)
    begin
      start_nxt = I_START.val;
    end
    case (state_r)
      adcsq_pkg::ST_STOP:
      begin
        start_nxt = 1'b0;
        if (I_ENABLE)
        begin
          // RL17 wait mode skips standby
          // RL1 no-wait enters standby
          state_nxt = wait_md ? adcsq_pkg::ST_TRIG : adcsq_pkg::ST_STBY;
        end
      end
      adcsq_pkg::ST_STBY:
      begin
        if (!I_ENABLE)
        begin
          // RL14 standby to stop
          state_nxt = adcsq_pkg::ST_STOP;
          start_nxt = 1'b0;
        end
        else if (st_set)
        begin
          // RL3 arm only, no conversion
          state_nxt = adcsq_pkg::ST_TRIG;
        end
      end
      adcsq_pkg::ST_TRIG:
      begin
        if (!I_ENABLE)
        begin
          state_nxt = adcsq_pkg::ST_STOP;
          start_nxt = 1'b0;
        end
        else if (trig_ok)
        begin
          // RL4 trigger starts conversion
          // RL18 hardware sets start, wins over a clear
          // RL7 scan begins at slot zero
          state_nxt = adcsq_pkg::ST_CONV;
          start_nxt = 1'b1;
          slot_nxt  = adcsq_pkg::SLOT_FIRST;
          cnt_nxt   = adcsq_pkg::CNT_RST;
          go_nxt    = 1'b1;
        end
        else if (st_clr && !wait_md)
        begin
          state_nxt = adcsq_pkg::ST_STBY;
        end
        else if (wait_md)
        begin
          // wait mode keeps the start bit low until a trigger
          start_nxt = 1'b0;
        end
      end
      adcsq_pkg::ST_CONV:
      begin
        if (!I_ENABLE)
        begin
          state_nxt = adcsq_pkg::ST_STOP;
          start_nxt = 1'b0;
        end
        else if (st_clr && !(wait_md && trig_ok))
        begin
          // RL13 no-wait clear: standby, powered
          // RL20 wait clear: trigger standby, unpowered
          state_nxt = wait_md ? adcsq_pkg::ST_TRIG : adcsq_pkg::ST_STBY;
          start_nxt = 1'b0;
        end
        else if (restart)
        begin
          // RL10 trigger restarts sequence
          // RL11 channel write restarts on new input
          // RL12 start rewrite restarts at first
          start_nxt = 1'b1;
          slot_nxt  = adcsq_pkg::SLOT_FIRST;
          cnt_nxt   = adcsq_pkg::CNT_RST;
          go_nxt    = 1'b1;
        end
        else if (cnt_done)
        begin
          // RL5 store result and raise irq
          res_nxt = I_SAMPLE;
          eoc_nxt = 1'b1;
          cnt_nxt = adcsq_pkg::CNT_RST;
          if (!last_slot)
          begin
            // RL7 next scan slot
            slot_nxt = slot_r + 2'h1;
            go_nxt   = 1'b1;
          end
          else if (!one_shot)
          begin
            // RL8 scan pass repeats
            // RL19 select converts back to back
            slot_nxt = adcsq_pkg::SLOT_FIRST;
            go_nxt   = 1'b1;
          end
          else if (wait_md)
          begin
            // wait one-shot drops start and idles unpowered
            state_nxt = adcsq_pkg::ST_TRIG;
            start_nxt = 1'b0;
          end
          else
          begin
            // RL6 select one-shot keeps start
            // RL9 scan one-shot keeps start
            state_nxt = adcsq_pkg::ST_TRIG;
            slot_nxt  = adcsq_pkg::SLOT_FIRST;
          end
        end
        else
        begin
          cnt_nxt = cnt_r + 12'h001;
        end
      end
      default:
      begin
        state_nxt = adcsq_pkg::ST_STOP;
        start_nxt = 1'b0;
      end
    endcase
  end

  // ***********************************************************************
  // registers
  // ***********************************************************************
  // control state, cleared by the synchronous reset
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      state_r  <= adcsq_pkg::ST_STOP;
      start_r  <= 1'b0;
      ch_r     <= adcsq_pkg::CH_RST;
      slot_r   <= adcsq_pkg::SLOT_FIRST;
      cnt_r    <= adcsq_pkg::CNT_RST;
      trig_d_r <= 1'b0;
      go_r     <= 1'b0;
      eoc_r    <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      start_r  <= start_nxt;
      ch_r     <= ch_nxt;
      slot_r   <= slot_nxt;
      cnt_r    <= cnt_nxt;
      trig_d_r <= I_HW_TRIG;
      go_r     <= go_nxt;
      eoc_r    <= eoc_nxt;
    end
  end

  // result keeps its last value across aborts; partial data never lands
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      res_r <= adcsq_pkg::RES_RST;
    end
    else
    begin
      res_r <= res_nxt;
    end
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  assign O_START_BIT    = start_r;
  assign O_STATE        = state_r;
  // wait mode powers the converter only while converting
  assign O_CONV_POWER   = (state_r == adcsq_pkg::ST_CONV)
                        | (!wait_md && state_r != adcsq_pkg::ST_STOP);
  assign O_CONV_CH      = slot_ch(ch_r, slot_r, scan_md);
  assign O_SAMPLE_START = go_r;
  assign O_RESULT       = res_r;
  assign O_RESULT_HIGH  = res_r[adcsq_pkg::SAMPLE_W-1 -: adcsq_pkg::HIGH_W];
  assign O_EOC_IRQ      = eoc_r;

endmodule : adcsq_top

// *** adcsq_props.sv ***
/*
  adcsq_props: port-level timing checks of the converter sequencer.
  assumes: bound onto adcsq_top; one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module adcsq_props
#(
  parameter int CONV_CYCLES = adcsq_pkg::CONV_CYC       // conversion window
)
(
  input wire logic                           I_CLK,
  input wire logic                           I_SRST,
  input wire logic                           I_ENABLE,
  input wire adcsq_pkg::adcsq_start_t        I_START,
  input wire adcsq_pkg::adcsq_chsel_t        I_CHSEL,
  input wire adcsq_pkg::adcsq_mode_t         I_MODE,
  input wire logic                           I_HW_TRIG,
  input wire logic [adcsq_pkg::SAMPLE_W-1:0] I_SAMPLE,
  input wire logic                           O_START_BIT,
  input wire logic [3:0]                     O_STATE,
  input wire logic                           O_CONV_POWER,
  input wire logic [adcsq_pkg::CH_W-1:0]     O_CONV_CH,
  input wire logic                           O_SAMPLE_START,
  input wire logic [adcsq_pkg::SAMPLE_W-1:0] O_RESULT,
  input wire logic [adcsq_pkg::HIGH_W-1:0]   O_RESULT_HIGH,
  input wire logic                           O_EOC_IRQ
);
  // ************************************************************
  // helpers
  // ************************************************************
  logic        trig_q_r;                                // trigger one cycle late
  logic [11:0] win_r;                                   // cycles since launch
  wire         trig_ev = I_HW_TRIG && !trig_q_r;        // only a rising edge counts
  wire         run_ok  = (O_STATE == 4'h8) && I_ENABLE; // converting, not dropped
  wire         clr_wr  = I_START.wr && !I_START.val;    // start bit cleared
  // counter restarts on each launch, so aborted windows never reach the end
  always_ff @(posedge I_CLK)
  begin
    trig_q_r <= I_SRST ? 1'b0 : I_HW_TRIG;
    win_r    <= I_SRST ? 12'h000 : (O_SAMPLE_START ? 12'h001 : win_r + 12'h001);
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  sequence s_launch;
    O_SAMPLE_START && (O_STATE == 4'h8);
  endsequence
  // ************************************************************
  // assertions
  // ************************************************************
  a_en_to_stby:
    assert property (O_STATE == 4'h1 && I_ENABLE && !I_MODE.wait_mode |=> O_STATE == 4'h2)
    else $error("enable from stop missed standby");
  a_wait_en:
    assert property (O_STATE == 4'h1 && I_ENABLE && I_MODE.wait_mode
      |=> O_STATE == 4'h4 && !O_START_BIT && !O_CONV_POWER) else $error("wait enable wrong");
  a_arm_only:
    assert property (O_STATE == 4'h2 && I_ENABLE && I_START.wr && I_START.val
      && !I_MODE.wait_mode |=> O_STATE == 4'h4 && O_START_BIT) else $error("start did not arm");
  a_idle_quiet:
    assert property (O_STATE[1:0] != 2'h0 |=> !O_SAMPLE_START)
    else $error("launch from stop or standby");
  a_en_drop:
    assert property (O_STATE == 4'h2 && !I_ENABLE |=> O_STATE == 4'h1)
    else $error("enable clear missed stop");
  a_trig_go:
    assert property (O_STATE == 4'h4 && I_ENABLE && trig_ev && !I_START.wr
      && (I_MODE.wait_mode || O_START_BIT) |=> s_launch ##0 (O_START_BIT && O_CONV_POWER))
    else $error("trigger did not launch");
  a_restart_go:
    assert property (run_ok && !clr_wr && (trig_ev || I_CHSEL.wr || I_START.wr)
      |=> s_launch ##0 (!$past(I_CHSEL.wr) || O_CONV_CH == $past(I_CHSEL.ch)))
    else $error("restart did not relaunch");
  a_eoc_time:
    assert property (O_EOC_IRQ |-> win_r == CONV_CYCLES)
    else $error("conversion end at wrong cycle");
  a_result_load:
    assert property (O_EOC_IRQ |-> O_RESULT == $past(I_SAMPLE)
      && O_RESULT_HIGH == O_RESULT[9:2]) else $error("result not stored");
  a_oneshot_end:
    assert property (O_EOC_IRQ && !I_MODE.wait_mode && I_MODE.one_shot && !I_MODE.scan_mode
      |-> O_STATE == 4'h4 && O_START_BIT) else $error("one-shot end wrong");
  a_seq_next:
    assert property (O_EOC_IRQ && !I_MODE.one_shot |-> O_SAMPLE_START)
    else $error("sequential did not continue");
  a_stop_clear:
    assert property (run_ok && clr_wr && !trig_ev |=> O_STATE ==
      (I_MODE.wait_mode ? 4'h4 : 4'h2) && O_CONV_POWER == !I_MODE.wait_mode)
    else $error("start clear mid-conversion wrong");
endmodule : adcsq_props

// *** tb.sv ***
/*
  tb: directed bench of the sequencer through its control ports.
  assumes: adcsq_pkg compiled first; sample derived from the live channel.
*/
`timescale 1ns/1ps
module tb;
  localparam int CONV_CYCLES = 6;                    // short window, brief run
  logic                    I_CLK = 1'b0;             // system clock
  logic                    I_SRST, I_ENABLE, I_HW_TRIG;
  adcsq_pkg::adcsq_start_t I_START;                  // start bit write
  adcsq_pkg::adcsq_chsel_t I_CHSEL;                  // channel write
  adcsq_pkg::adcsq_mode_t  I_MODE;                   // mode levels
  logic [9:0]              I_SAMPLE, O_RESULT;
  logic [7:0]              O_RESULT_HIGH;
  logic [4:0]              O_CONV_CH;
  logic [3:0]              O_STATE;
  logic                    O_START_BIT, O_CONV_POWER, O_SAMPLE_START, O_EOC_IRQ;
  int                      n_errors, total_checks, n_starts, n0;
  adcsq_top #(.CONV_CYCLES(CONV_CYCLES)) adcsq_top_inst (.I_CLK(I_CLK), .I_SRST(I_SRST),
    .I_ENABLE(I_ENABLE), .I_START(I_START), .I_CHSEL(I_CHSEL), .I_MODE(I_MODE),
    .I_HW_TRIG(I_HW_TRIG), .I_SAMPLE(I_SAMPLE), .O_START_BIT(O_START_BIT),
    .O_STATE(O_STATE), .O_CONV_POWER(O_CONV_POWER), .O_CONV_CH(O_CONV_CH),
    .O_SAMPLE_START(O_SAMPLE_START), .O_RESULT(O_RESULT), .O_RESULT_HIGH(O_RESULT_HIGH),
    .O_EOC_IRQ(O_EOC_IRQ));
  // ************************************************************
  // clock, analog stand-in, launch counter
  // ************************************************************
  always #5 I_CLK = ~I_CLK;
  // sample tags the channel, so each result shows which input was read
  always @(posedge I_CLK)
  begin
    #1;
    I_SAMPLE = {5'h15, O_CONV_CH};
    if (O_SAMPLE_START === 1'b1)
      n_starts++;
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic tick;
    @(posedge I_CLK);
    #1;
  endtask : tick
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // strobes last one cycle, then a quiet cycle before the next request
  task automatic wr_start(input logic v);
    I_START = '{1'b1, v};
    tick;
    I_START = '{1'b0, 1'b0};
    tick;
  endtask : wr_start
  task automatic wr_ch(input logic [4:0] c);
    I_CHSEL = '{1'b1, c};
    tick;
    I_CHSEL = '{1'b0, 5'h00};
    tick;
  endtask : wr_ch
  task automatic trig(input int n);
    I_HW_TRIG = 1'b1;
    repeat (n) tick;
    I_HW_TRIG = 1'b0;
    tick;
  endtask : trig
  // mode only changes in stop, so enable drops first
  task automatic go_mode(input logic [2:0] m);
    I_ENABLE = 1'b0;
    tick;
    I_MODE = adcsq_pkg::adcsq_mode_t'(m);
    I_ENABLE = 1'b1;
    tick;
  endtask : go_mode
  task automatic wait_irq(input logic [4:0] ch);
    int i;
    tick;
    for (i = 0; i < 40 && O_EOC_IRQ !== 1'b1; i++)
      tick;
    if (i == 40)
    begin
      n_errors++;
      end_sim;
    end
    chk("result", O_RESULT, {5'h15, ch});
    chk("result_high", O_RESULT_HIGH, {5'h15, ch[4:2]});
  endtask : wait_irq
  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    {I_SRST, I_ENABLE, I_HW_TRIG, I_START, I_CHSEL, I_MODE} = '0;
    I_SRST = 1'b1;
    I_SAMPLE = 10'h000;
    repeat (20) tick;
    I_SRST = 1'b0;
    chk("reset", {O_STATE, O_START_BIT, O_CONV_POWER}, 6'h04);
    go_mode(3'h1);
    chk("state", O_STATE, 4'h2);
    trig(1);
    chk("state", O_STATE, 4'h2);
    I_ENABLE = 1'b0;
    tick;
    chk("state", O_STATE, 4'h1);
    wr_start(1'b1);
    chk("start", {O_STATE, O_START_BIT}, 5'h02);
    I_ENABLE = 1'b1;
    tick;
    repeat (8) tick;
    wr_ch(5'h07);
    wr_start(1'b1);
    chk("armed", {O_STATE, O_START_BIT}, 5'h09);
    n0 = n_starts;
    trig(3);
    wait_irq(5'h07);
    chk("launches", n_starts - n0, 1);
    chk("after", {O_STATE, O_START_BIT}, 5'h09);
    trig(1);
    wr_ch(5'h09);
    wait_irq(5'h09);
    n0 = n_starts;
    trig(1);
    trig(1);
    wait_irq(5'h09);
    chk("launches", n_starts - n0, 2);
    n0 = n_starts;
    trig(1);
    wr_start(1'b1);
    wait_irq(5'h09);
    chk("launches", n_starts - n0, 2);
    trig(1);
    wr_start(1'b0);
    chk("clear", {O_STATE, O_CONV_POWER}, 5'h05);
    go_mode(3'h3);
    wr_ch(5'h1e);
    wr_start(1'b1);
    trig(1);
    for (int k = 0; k < 4; k++)
      wait_irq(5'h1e + k[4:0]);
    chk("after", {O_STATE, O_START_BIT}, 5'h09);
    trig(1);
    wait_irq(5'h1e);
    trig(1);
    wait_irq(5'h1e);
    go_mode(3'h2);
    wr_start(1'b1);
    trig(1);
    for (int k = 0; k < 6; k++)
      wait_irq(5'h1e + {3'h0, k[1:0]});
    go_mode(3'h4);
    chk("wait", {O_STATE, O_START_BIT, O_CONV_POWER}, 6'h10);
    trig(1);
    chk("wait", {O_STATE, O_START_BIT, O_CONV_POWER}, 6'h23);
    for (int k = 0; k < 3; k++)
      wait_irq(5'h1e);
    wr_start(1'b0);
    chk("wait", {O_STATE, O_START_BIT, O_CONV_POWER}, 6'h10);
    I_ENABLE = 1'b0;
    tick;
    n0 = n_starts;
    trig(1);
    chk("off_state", O_STATE, 4'h1);
    chk("off_launches", n_starts - n0, 0);
    end_sim;
  end
endmodule : tb
bind adcsq_top adcsq_props #(.CONV_CYCLES(CONV_CYCLES)) adcsq_props_inst (.I_CLK(I_CLK),
  .I_SRST(I_SRST), .I_ENABLE(I_ENABLE), .I_START(I_START), .I_CHSEL(I_CHSEL),
  .I_MODE(I_MODE), .I_HW_TRIG(I_HW_TRIG), .I_SAMPLE(I_SAMPLE), .O_START_BIT(O_START_BIT),
  .O_STATE(O_STATE), .O_CONV_POWER(O_CONV_POWER), .O_CONV_CH(O_CONV_CH),
  .O_SAMPLE_START(O_SAMPLE_START), .O_RESULT(O_RESULT), .O_RESULT_HIGH(O_RESULT_HIGH),
  .O_EOC_IRQ(O_EOC_IRQ));
